// [rtl/chain_ram.v]
/*
  one indirect ram: synchronous write, registered read.
  assumes address stays in range; caller handles busy sequencing.
*/
`timescale 1ns/1ps
module chain_ram #(
  parameter DEPTH = 512,
  parameter AW    = 9,
  parameter DW    = 9
) (
  input  wire          mclk_in,
  input  wire          wr_in,
  input  wire [AW-1:0] waddr_in,
  input  wire [DW-1:0] wdata_in,
  input  wire [AW-1:0] raddr_in,
  output reg  [DW-1:0] rdata_out
);
  reg [DW-1:0] mem [0:DEPTH-1];

  always @(posedge mclk_in) begin
    if (wr_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end
endmodule // chain_ram

// [rtl/tx_chain_regs.vh]
/*
  register offsets, field positions, reset values and timing counts
  for the transmit fifo chain configuration block.
  assumes a 32-bit classic wishbone byte address space.
*/
`ifndef TX_CHAIN_REGS_VH
`define TX_CHAIN_REGS_VH

`define TX_START_PTR_SELECT_ADDR 12'h980
`define TX_START_PTR_DATA_ADDR   12'h984
`define TX_LINK_SELECT_ADDR      12'h990
`define TX_LINK_DATA_ADDR        12'h994
`define TX_LOW_MARK_SELECT_ADDR  12'h9a0
`define TX_LOW_MARK_DATA_ADDR    12'h9a4

`define BUSY_BIT                 15
`define DIR_BIT                  14
`define PTR_MSB                  8
`define CHAN_MSB                 5

`define SELECT_RESET             16'h0000
`define DATA_RESET               9'h000
`define CHAN_COUNT               40
`define CHAN_LAST                6'h27
`define ACCESS_CYCLES            2'h2

`endif

// [rtl/tx_fifo_chain_config.v]
/*
  transmit fifo chain configuration: three indirect rams (start pointer,
  next-block link, low mark) behind a classic wishbone slave, plus the
  hdlc read-pointer walk and the dma refill request.
  assumes one clock, an hdlc transmitter that pulses block_done per
  channel, and a dma that accepts refill requests as levels.
*/
`timescale 1ns/1ps
`include "tx_chain_regs.vh"

// How it works
// - channel codes 00h..27h select channels 1..40
// - bit 14 set reads, clear writes
// - start read fetches current pointer into data
// - write copies data register into ram slot
// - bit 15 busy during every indirect access
// - busy clears when data valid or written
// - nine-bit start pointer per channel, any block
// - start read returns live hdlc pointer
// - link ram indexed by nine-bit block id
// - link read fetches next entry, clears busy
// - link entries are nine-bit next block numbers
// - low mark ram per channel, same protocol
// - refill request when remaining reaches low mark
module tx_fifo_chain_config #(
  parameter CHANS = 40,
  parameter BLOCKS = 512
) (
  input  wire        mclk_in,
  input  wire        rst_b_in,
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [11:0] wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  input  wire        block_done_in,
  input  wire [5:0]  block_done_chan_in,
  input  wire [5:0]  ptr_chan_in,
  input  wire [8:0]  blocks_left_in,
  output reg  [8:0]  cur_ptr_out,
  output reg  [39:0] refill_req_out
);
  localparam IDLE = 2'b00;
  localparam WAIT = 2'b01;
  localparam DONE = 2'b10;

  // select registers: index, dir, busy per ram (0 start, 1 link, 2 low mark)
  reg  [8:0]  idx_q [0:2];
  reg  [2:0]  dir_q;
  reg  [2:0]  busy_q;
  reg  [8:0]  data_q [0:2];
  reg  [1:0]  st_q;
  reg  [1:0]  which_q;
  reg  [1:0]  cnt_q;

  // live per-channel read pointer, loaded by start writes
  reg  [8:0]  live_ptr_q [0:CHANS-1];

  wire        req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire        wr_req = req & wb_we_in & wb_sel_in[1] & wb_sel_in[0];
  wire [8:0]  link_rd;
  wire [8:0]  mark_rd;
  reg         link_wr;
  reg         mark_wr;
  reg  [1:0]  sel_hit;
  reg         is_sel;
  reg         is_data;
  reg  [8:0]  idx_d;
  reg  [31:0] rd_word;
  reg  [8:0]  start_rd;
  reg         start_wr;
  reg         refill_hit;
  integer     i;
  integer     j;

  always @* begin
    sel_hit = 2'd0;
    is_sel  = 1'b0;
    is_data = 1'b0;
    case (wb_adr_in)
      `TX_START_PTR_SELECT_ADDR: begin
        is_sel  = 1'b1;
        sel_hit = 2'd0;
      end
      `TX_START_PTR_DATA_ADDR: begin
        is_data = 1'b1;
        sel_hit = 2'd0;
      end
      `TX_LINK_SELECT_ADDR: begin
        is_sel  = 1'b1;
        sel_hit = 2'd1;
      end
      `TX_LINK_DATA_ADDR: begin
        is_data = 1'b1;
        sel_hit = 2'd1;
      end
      `TX_LOW_MARK_SELECT_ADDR: begin
        is_sel  = 1'b1;
        sel_hit = 2'd2;
      end
      `TX_LOW_MARK_DATA_ADDR: begin
        is_data = 1'b1;
        sel_hit = 2'd2;
      end
      default: begin
        is_sel  = 1'b0;
        is_data = 1'b0;
      end
    endcase
  end

  // read word: select fields or data in the low half, all else zero
  always @* begin
    rd_word = 32'h0000_0000;
    if (is_sel) begin
      rd_word[`BUSY_BIT] = busy_q[sel_hit];
      rd_word[`DIR_BIT]  = dir_q[sel_hit];
      rd_word[8:0]       = idx_q[sel_hit];
    end else if (is_data) begin
      rd_word[8:0] = data_q[sel_hit];
    end
  end

  // channel selects keep only the six index bits
  always @* begin
    idx_d = {3'b000, wb_dat_in[`CHAN_MSB:0]};
    if (sel_hit == 2'd1) begin
      idx_d = wb_dat_in[`PTR_MSB:0];
    end
  end

  // link ram: index is a nine-bit block id, 000h..1ffh
  chain_ram #(.DEPTH(BLOCKS), .AW(9), .DW(9)) link_ram (
    .mclk_in   (mclk_in),
    .wr_in     (link_wr),
    .waddr_in  (idx_q[1]),
    .wdata_in  (data_q[1]),
    .raddr_in  (idx_q[1]),
    .rdata_out (link_rd)
  );

  // low mark ram, one entry per channel
  chain_ram #(.DEPTH(64), .AW(6), .DW(9)) mark_ram (
    .mclk_in   (mclk_in),
    .wr_in     (mark_wr),
    .waddr_in  (idx_q[2][5:0]),
    .wdata_in  (data_q[2]),
    .raddr_in  (ptr_chan_in),
    .rdata_out (mark_rd)
  );

  // a second port for host reads of the low mark
  reg [8:0] mark_shadow_q [0:63];
  reg [8:0] mark_host_q;

  // start writes land on the last wait cycle, link and mark on both
  always @* begin
    link_wr  = (st_q == WAIT) && (which_q == 2'd1) && !dir_q[1];
    mark_wr  = (st_q == WAIT) && (which_q == 2'd2) && !dir_q[2];
    start_wr = (st_q == WAIT) && (which_q == 2'd0) && !dir_q[0] && (cnt_q == 2'd1)
               && (idx_q[0][5:0] <= `CHAN_LAST);
  end

  // codes past the last channel read back zero, not an unknown
  always @* begin
    start_rd = 9'h000;
    if (idx_q[0][5:0] <= `CHAN_LAST) begin
      start_rd = live_ptr_q[idx_q[0][5:0]];
    end
  end

  // bus slave and indirect sequencer
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
      dir_q      <= 3'b000;
      busy_q     <= 3'b000;
      st_q       <= IDLE;
      which_q    <= 2'd0;
      cnt_q      <= 2'd0;
      for (i = 0; i < 3; i = i + 1) begin
        idx_q[i]  <= 9'h000;
        data_q[i] <= `DATA_RESET;
      end
    end else begin
      wb_ack_out <= req;
      if (req) begin
        wb_dat_out <= rd_word;
      end
      case (st_q)
        IDLE: begin
          // host writes reach the data registers only while idle
          if (wr_req && is_data) begin
            data_q[sel_hit] <= wb_dat_in[`PTR_MSB:0];
          end
          // a select write starts an access; ignored while busy
          if (wr_req && is_sel) begin
            idx_q[sel_hit]  <= idx_d;
            dir_q[sel_hit]  <= wb_dat_in[`DIR_BIT];
            busy_q[sel_hit] <= 1'b1;
            which_q <= sel_hit;
            cnt_q   <= `ACCESS_CYCLES;
            st_q    <= WAIT;
          end
        end
        WAIT: begin
          // ram reads settle over the counted wait cycles
          if (cnt_q == 2'd1) begin
            st_q <= DONE;
          end
          cnt_q <= cnt_q - 2'd1;
        end
        DONE: begin
          if (dir_q[which_q]) begin
            // reads load the data register as busy clears
            case (which_q)
              2'd0: begin
                data_q[0] <= start_rd;
              end
              2'd1: begin
                data_q[1] <= link_rd;
              end
              default: begin
                data_q[2] <= mark_host_q;
              end
            endcase
          end
          busy_q[which_q] <= 1'b0;
          st_q <= IDLE;
        end
        default: st_q <= IDLE;
      endcase
    end
  end

  always @(posedge mclk_in) begin
    if (mark_wr) begin
      mark_shadow_q[idx_q[2][5:0]] <= data_q[2];
    end
    mark_host_q <= mark_shadow_q[idx_q[2][5:0]];
  end

  // live pointer: start writes load it, finished blocks follow the link
  wire [8:0] walk_next;
  chain_ram #(.DEPTH(BLOCKS), .AW(9), .DW(9)) walk_ram (
    .mclk_in   (mclk_in),
    .wr_in     (link_wr),
    .waddr_in  (idx_q[1]),
    .wdata_in  (data_q[1]),
    .raddr_in  (live_ptr_q[block_done_chan_in]),
    .rdata_out (walk_next)
  );
  reg       walk_q;
  reg [5:0] walk_chan_q;

  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      walk_q      <= 1'b0;
      walk_chan_q <= 6'h00;
      cur_ptr_out <= 9'h000;
      for (j = 0; j < CHANS; j = j + 1) begin
        live_ptr_q[j] <= 9'h000;
      end
    end else begin
      // unused channel codes never move a pointer
      walk_q      <= block_done_in && (block_done_chan_in <= `CHAN_LAST);
      walk_chan_q <= block_done_chan_in;
      if (walk_q) begin
        live_ptr_q[walk_chan_q] <= walk_next;
      end
      // host start write takes precedence over the walk
      if (start_wr) begin
        live_ptr_q[idx_q[0][5:0]] <= data_q[0];
      end
      cur_ptr_out <= (ptr_chan_in <= `CHAN_LAST) ? live_ptr_q[ptr_chan_in] : 9'h000;
    end
  end

  // refill request for the channel being reported
  reg [5:0] rq_chan_q;
  reg [8:0] left_q;

  // a zero low mark is an invalid setting and never asks for data
  always @* begin
    refill_hit = (mark_rd != 9'h000) && (left_q <= mark_rd);
  end

  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rq_chan_q      <= 6'h00;
      left_q         <= 9'h000;
      refill_req_out <= 40'h00_0000_0000;
    end else begin
      // the named channel is judged two edges after it is presented
      rq_chan_q <= ptr_chan_in;
      left_q    <= blocks_left_in;
      if (rq_chan_q <= `CHAN_LAST) begin
        refill_req_out[rq_chan_q] <= refill_hit;
      end
    end
  end
endmodule // tx_fifo_chain_config

// [tb/tx_fifo_chain_config_monitor.sv]
/* checker for tx_fifo_chain_config wishbone answers.
   assumes the register header is on the include path. */
`timescale 1ns/1ps
`include "tx_chain_regs.vh"
module tx_fifo_chain_config_monitor (
  input wire        mclk_in,
  input wire        rst_b_in,
  input wire        wb_cyc_in,
  input wire        wb_stb_in,
  input wire        wb_we_in,
  input wire [11:0] wb_adr_in,
  input wire [31:0] wb_dat_out,
  input wire        wb_ack_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  wire take = wb_cyc_in & wb_stb_in & !wb_ack_out;
  wire sel_a = wb_adr_in == `TX_START_PTR_SELECT_ADDR || wb_adr_in == `TX_LINK_SELECT_ADDR
            || wb_adr_in == `TX_LOW_MARK_SELECT_ADDR;
  wire dat_a = wb_adr_in == `TX_START_PTR_DATA_ADDR || wb_adr_in == `TX_LINK_DATA_ADDR
            || wb_adr_in == `TX_LOW_MARK_DATA_ADDR;
  reg [3:0] since_q;
  // cycles since the last select write, saturating
  always @(posedge mclk_in or negedge rst_b_in)
    if (!rst_b_in) since_q <= 4'hf;
    else if (take && wb_we_in && sel_a) since_q <= 4'h0;
    else if (since_q != 4'hf) since_q <= since_q + 4'h1;
  sequence s_read;
    take && !wb_we_in;
  endsequence
  a_ack_follows_take: assert property (take |=> wb_ack_out)
    else $error("no ack one cycle after request");
  a_ack_one_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_out |-> $past(take))
    else $error("ack without request");
  a_unmapped_zero: assert property (s_read ##0 !(sel_a || dat_a) |=> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (s_read |=> wb_dat_out[31:16] == 16'h0)
    else $error("upper half not zero");
  a_data_nine_bits: assert property (s_read ##0 dat_a |=> wb_dat_out[15:9] == 7'h0)
    else $error("data register above nine bits");
  a_select_reserved: assert property (s_read ##0 sel_a |=> wb_dat_out[13:9] == 5'h0)
    else $error("select reserved bits set");
  a_busy_bounded: assert property (s_read ##0 sel_a |=> !wb_dat_out[15] || since_q < 4'ha)
    else $error("busy held too long");
endmodule // tx_fifo_chain_config_monitor
bind tx_fifo_chain_config tx_fifo_chain_config_monitor tx_fifo_chain_config_monitor_i (
  .mclk_in(mclk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out));

// [tb/tx_fifo_chain_config_tb_top.sv]
/* self-checking bench for tx_fifo_chain_config over classic wishbone.
   assumes the register header is on the include path. */
`timescale 1ns/1ps
`include "tx_chain_regs.vh"
module tx_fifo_chain_config_tb_top;
  reg         mclk_in = 0;
  reg         rst_b_in = 0;
  reg         cyc = 0, we = 0, bd = 0;
  reg  [11:0] adr = 0;
  reg  [31:0] wdat = 0, r;
  reg  [5:0]  bd_ch = 0, p_ch = 0, c;
  reg  [8:0]  left = 9'h1ff, v, b, s, n;
  wire [31:0] rdat;
  wire        ack;
  wire [8:0]  cur;
  wire [39:0] refill;
  integer     n_errors = 0, cmp_count = 0, ticks = 0, k;
  always #10 mclk_in = ~mclk_in;
  tx_fifo_chain_config tx_fifo_chain_config_i (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .block_done_in(bd),
    .block_done_chan_in(bd_ch), .ptr_chan_in(p_ch), .blocks_left_in(left),
    .cur_ptr_out(cur), .refill_req_out(refill));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  function [31:0] sel_word(input rd, input [8:0] idx);
    begin
      sel_word = {17'h0, rd, 5'h0, idx};
    end
  endfunction
  function exp_refill(input [8:0] left_v, input [8:0] mark);
    begin
      exp_refill = (mark != 9'h000) && (left_v <= mark);
    end
  endfunction
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task bus(input w, input [11:0] a, input [31:0] d);
    begin
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge mclk_in); while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      @(posedge mclk_in);
    end
  endtask
  // data write first on writes, then select write, poll busy, then fetch data on reads
  task ind(input [11:0] a, input rd, input [8:0] idx, input [8:0] val);
    begin
      if (!rd) bus(1'b1, a + 12'h004, {23'h0, val});
      bus(1'b1, a, sel_word(rd, idx));
      r = 32'h0000_8000;
      while (r[15] !== 1'b0) bus(1'b0, a, 32'h0);
      check(r, sel_word(rd, idx));
      if (rd) bus(1'b0, a + 12'h004, 32'h0);
    end
  endtask
  always @(posedge mclk_in) begin
    ticks = ticks + 1;
    if (ticks == 8000) begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  initial begin
    k = $urandom(11506);
    repeat (12) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    bus(1'b0, `TX_LINK_SELECT_ADDR, 32'h0);
    check(r, 32'h0);
    bus(1'b0, 12'h9b0, 32'h0);
    check(r, 32'h0);
    for (k = 0; k < 8; k = k + 1) begin
      b = (k == 0) ? 9'h000 : (k == 1) ? 9'h1ff : $urandom;
      v = b + 9'h001 + $urandom % 510; // never b itself
      ind(`TX_LINK_SELECT_ADDR, 1'b0, b, v);
      ind(`TX_LINK_SELECT_ADDR, 1'b1, b, 9'h0);
      check(r, {23'h0, v});
    end
    for (k = 0; k < 2; k = k + 1) begin
      c = k ? `CHAN_LAST : 6'h00;
      v = 9'h001 + $urandom % 200;
      p_ch <= c;
      ind(`TX_LOW_MARK_SELECT_ADDR, 1'b0, {3'h0, c}, v);
      ind(`TX_LOW_MARK_SELECT_ADDR, 1'b1, {3'h0, c}, 9'h0);
      check(r, {23'h0, v});
      left <= v;
      repeat (3) @(posedge mclk_in);
      check(refill[c], exp_refill(v, v));
      left <= v + 9'h001;
      repeat (3) @(posedge mclk_in);
      check(refill[c], exp_refill(v + 9'h001, v));
    end
    s = $urandom % 256;
    n = s + 9'h100;
    ind(`TX_LINK_SELECT_ADDR, 1'b0, s, n);
    ind(`TX_START_PTR_SELECT_ADDR, 1'b0, 9'h005, s);
    p_ch <= 6'h05;
    ind(`TX_START_PTR_SELECT_ADDR, 1'b1, 9'h005, 9'h0);
    check(r, {23'h0, s});
    check(cur, s);
    bd_ch <= 6'h05;
    bd <= 1'b1;
    @(posedge mclk_in);
    bd <= 1'b0;
    repeat (3) @(posedge mclk_in);
    check(cur, n);
    ind(`TX_START_PTR_SELECT_ADDR, 1'b1, 9'h005, 9'h0);
    check(r, {23'h0, n});
    // mid-run reset: selects and live pointers return to zero
    rst_b_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    bus(1'b0, `TX_START_PTR_SELECT_ADDR, 32'h0);
    check(r, 32'h0);
    check(cur, 9'h000);
    print_verdict;
  end
endmodule // tx_fifo_chain_config_tb_top
